// ===== hw/core_special_registers.sv
// Special function register core: indirect windows, accumulator, PC low, flags, port A
`timescale 1ns/1ps
`include "core_sfr_map.svh"

module core_special_registers #(
  parameter int PORT_W    = 8,
  parameter int GP_DEPTH  = `GP_DEPTH_DEF,
  parameter int BANKS     = `BANKS_DEF,
  parameter int PC_W      = `PC_W_DEF,
  parameter bit SMALL_MEM = 1'b1
) (
  // Clock and reset
  input  wire logic                        SYS_CLK,
  input  wire logic                        RST,
  // Data memory access from the execution unit
  input  wire core_sfr_pkg::mem_req_t      MEM_REQ,
  output logic [7:0]                       MEM_RDATA,
  output logic                             MEM_RVALID,
  // ALU issue
  input  wire logic                        ALU_GO,
  input  wire core_sfr_pkg::alu_op_t       ALU_OP,
  input  wire logic [7:0]                  ALU_OPERAND,
  output logic [7:0]                       ACC_VALUE,
  output logic [7:0]                       FLAGS_VALUE,
  // Program counter
  input  wire logic [PC_W-1:0]             PC_CURRENT,
  output logic                             PC_JUMP,
  output logic [PC_W-1:0]                  PC_TARGET,
  output logic                             DUMMY_CYCLE,
  // System events
  input  wire logic                        WDT_TIMEOUT,
  input  wire logic                        WATCHDOG_CLEAR_INSTRUCTION,
  input  wire logic                        HALT,
  // Port A pins
  input  wire logic [PORT_W-1:0]           PA_IN,
  output logic [PORT_W-1:0]                PA_OUT,
  output logic [PORT_W-1:0]                PA_OE_N
);

  localparam int ENTRIES = BANKS * GP_DEPTH;
  localparam int IDX_W   = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
  localparam int GP_END  = `GP_START + GP_DEPTH;

  // ----------------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------------
  logic [7:0]              pointer0_reg;
  logic [7:0]              pointer1_reg;
  logic                    bank_sel_reg;
  logic [7:0]              acc_reg;
  core_sfr_pkg::arith_flags_t arith_reg;
  logic                    wdt_flag_reg;
  logic                    sleep_flag_reg;
  logic [PORT_W-1:0]       port_a_value_reg;
  logic [PORT_W-1:0]       port_a_dir_reg;
  logic [7:0]              rdata_reg;
  logic                    rvalid_reg;
  logic                    pc_jump_reg;
  logic [PC_W-1:0]         pc_target_reg;
  logic                    dummy_reg;
  logic [7:0]              gp_mem [ENTRIES];

  // ----------------------------------------------------------------------------
  // Effective address: windows take their pointer's address
  // ----------------------------------------------------------------------------
  logic [7:0]              direct_addr;
  logic                    via_win0;
  logic                    via_win1;
  logic                    via_window;
  logic [7:0]              ptr_addr;
  logic [7:0]              eff_addr;
  logic                    eff_bank;
  logic                    eff_void;

  assign direct_addr = MEM_REQ.addr;
  assign via_win0    = (direct_addr == `ADDR_WINDOW0);
  assign via_win1    = (direct_addr == `ADDR_WINDOW1);
  assign via_window  = via_win0 | via_win1;
  // Bit 7 is dropped for addressing in the small variants
  assign ptr_addr    = via_win0 ? {pointer0_reg[7] & ~SMALL_MEM, pointer0_reg[6:0]} :
                                  {pointer1_reg[7] & ~SMALL_MEM, pointer1_reg[6:0]};
  assign eff_addr    = via_window ? ptr_addr : direct_addr;
  // Only pointer 1 through window 1 reaches bank 1
  assign eff_bank    = via_win1 & bank_sel_reg & (BANKS > 1);
  // A window pointing at a window reads zero and swallows writes
  assign eff_void    = via_window & ((ptr_addr == `ADDR_WINDOW0) |
                                     (ptr_addr == `ADDR_WINDOW1));

  // ----------------------------------------------------------------------------
  // Register hit decode on the effective address
  // ----------------------------------------------------------------------------
  logic hit_ptr0;
  logic hit_ptr1;
  logic hit_bank;
  logic hit_acc;
  logic hit_pcl;
  logic hit_flags;
  logic hit_pa_val;
  logic hit_pa_dir;
  logic hit_gp;
  logic wr_en;

  assign hit_ptr0   = ~eff_void & (eff_addr == `ADDR_POINTER0);
  assign hit_ptr1   = ~eff_void & (eff_addr == `ADDR_POINTER1);
  assign hit_bank   = ~eff_void & (eff_addr == `ADDR_BANK_SEL);
  assign hit_acc    = ~eff_void & (eff_addr == `ADDR_ACC);
  assign hit_pcl    = ~eff_void & (eff_addr == `ADDR_PCL);
  assign hit_flags  = ~eff_void & (eff_addr == `ADDR_FLAGS);
  assign hit_pa_val = ~eff_void & (eff_addr == `ADDR_PORT_A_VAL);
  assign hit_pa_dir = ~eff_void & (eff_addr == `ADDR_PORT_A_DIR);
  assign hit_gp     = ~eff_void & (int'(eff_addr) >= int'(`GP_START)) &
                      (int'(eff_addr) < GP_END);
  assign wr_en      = MEM_REQ.wr;

  // General RAM index: bank offset plus position inside the bank
  logic [IDX_W-1:0] gp_idx;
  logic [7:0]       gp_off;

  assign gp_off = eff_addr - `GP_START;
  assign gp_idx = eff_bank ? IDX_W'(GP_DEPTH) + IDX_W'(gp_off) : IDX_W'(gp_off);

  // ----------------------------------------------------------------------------
  // Read views
  // ----------------------------------------------------------------------------
  logic [7:0]        ptr0_view;
  logic [7:0]        ptr1_view;
  logic [7:0]        flags_view;
  logic [PORT_W-1:0] pa_view;
  logic [7:0]        rd_value;

  // Pointer bit 7 carries no address in small parts and reads as one
  assign ptr0_view  = SMALL_MEM ? {1'b1, pointer0_reg[6:0]} : pointer0_reg;
  assign ptr1_view  = SMALL_MEM ? {1'b1, pointer1_reg[6:0]} : pointer1_reg;
  // Top two bits are unimplemented
  assign flags_view = {2'b00, wdt_flag_reg, sleep_flag_reg, arith_reg};

  // Per pin: input pins show the pin, output pins show the latch
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_pa_read
      assign pa_view[gi] = port_a_dir_reg[gi] ? PA_IN[gi] : port_a_value_reg[gi];
    end
  endgenerate

  // Anything unmapped, below or above general RAM, reads zero
  assign rd_value = hit_ptr0   ? ptr0_view :
                    hit_ptr1   ? ptr1_view :
                    hit_bank   ? {7'h00, bank_sel_reg} :
                    hit_acc    ? acc_reg :
                    hit_pcl    ? PC_CURRENT[7:0] :
                    hit_flags  ? flags_view :
                    hit_pa_val ? 8'(pa_view) :
                    hit_pa_dir ? 8'(port_a_dir_reg) :
                    hit_gp     ? gp_mem[gp_idx] :
                    `UNUSED_READ;

  // ----------------------------------------------------------------------------
  // ALU
  // ----------------------------------------------------------------------------
  logic [7:0]                 alu_result;
  core_sfr_pkg::arith_flags_t alu_flags;
  core_sfr_pkg::arith_flags_t alu_update;
  core_sfr_pkg::arith_flags_t arith_next;

  alu_flag_unit u_alu (
    .a        (acc_reg),
    .b        (ALU_OPERAND),
    .carry_in (arith_reg.c),
    .op       (ALU_OP),
    .result   (alu_result),
    .flags    (alu_flags),
    .update   (alu_update)
  );

  // A software write to the flags wins over an ALU update in the same cycle
  assign arith_next = (wr_en & hit_flags) ? core_sfr_pkg::arith_flags_t'(MEM_REQ.wdata[3:0]) :
                      ALU_GO ? ((alu_flags & alu_update) | (arith_reg & ~alu_update)) :
                      arith_reg;

  // ----------------------------------------------------------------------------
  // Pointers and bank select
  // ----------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pointer0_reg <= `POINTER_RST;
      pointer1_reg <= `POINTER_RST;
      bank_sel_reg <= 1'b0;
    end else begin
      if (wr_en & hit_ptr0) begin
        pointer0_reg <= MEM_REQ.wdata;
      end
      if (wr_en & hit_ptr1) begin
        pointer1_reg <= MEM_REQ.wdata;
      end
      if (wr_en & hit_bank) begin
        bank_sel_reg <= MEM_REQ.wdata[0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Accumulator: ALU results land here unless software writes it in the same cycle
  // ----------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      acc_reg <= `ACC_RST;
    end else if (wr_en & hit_acc) begin
      acc_reg <= MEM_REQ.wdata;
    end else if (ALU_GO) begin
      acc_reg <= alu_result;
    end
  end

  // ----------------------------------------------------------------------------
  // Flag register; nothing here pushes it on call or interrupt entry
  // ----------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      arith_reg      <= `ARITH_FLAGS_RST;
      wdt_flag_reg   <= 1'b0;
      sleep_flag_reg <= 1'b0;
    end else begin
      arith_reg <= arith_next;
      // Time-out beats a clear in the same cycle so the event is kept
      if (WDT_TIMEOUT) begin
        wdt_flag_reg <= 1'b1;
      end else if (WATCHDOG_CLEAR_INSTRUCTION | HALT) begin
        wdt_flag_reg <= 1'b0;
      end
      // Sleep entry beats a simultaneous watchdog clear
      if (HALT) begin
        sleep_flag_reg <= 1'b1;
      end else if (WATCHDOG_CLEAR_INSTRUCTION) begin
        sleep_flag_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Program counter low byte: in-page jump plus a dummy cycle
  // ----------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pc_jump_reg   <= 1'b0;
      pc_target_reg <= '0;
      dummy_reg     <= 1'b0;
    end else begin
      pc_jump_reg <= wr_en & hit_pcl;
      dummy_reg   <= wr_en & hit_pcl;
      if (wr_en & hit_pcl) begin
        pc_target_reg <= {PC_CURRENT[PC_W-1:`PC_LOW_W], MEM_REQ.wdata};
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Port A latch and direction; direction resets to all inputs for safety
  // ----------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      port_a_value_reg <= PORT_W'(`PORT_VAL_RST);
      port_a_dir_reg   <= PORT_W'(`PORT_DIR_RST);
    end else begin
      if (wr_en & hit_pa_val) begin
        port_a_value_reg <= MEM_REQ.wdata[PORT_W-1:0];
      end
      if (wr_en & hit_pa_dir) begin
        port_a_dir_reg <= MEM_REQ.wdata[PORT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // General RAM; no reset since it is plain volatile data
  // ----------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (wr_en & hit_gp) begin
      gp_mem[gp_idx] <= MEM_REQ.wdata;
    end
  end

  // ----------------------------------------------------------------------------
  // Read data register; holds until the next read
  // ----------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= MEM_REQ.rd;
      if (MEM_REQ.rd) begin
        rdata_reg <= rd_value;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------------------
  assign MEM_RDATA   = rdata_reg;
  assign MEM_RVALID  = rvalid_reg;
  assign ACC_VALUE   = acc_reg;
  assign FLAGS_VALUE = {2'b00, wdt_flag_reg, sleep_flag_reg, arith_reg};
  assign PC_JUMP     = pc_jump_reg;
  assign PC_TARGET   = pc_target_reg;
  assign DUMMY_CYCLE = dummy_reg;
  // Direction one means input, so the active-low enable is the direction bit
  assign PA_OUT      = port_a_value_reg;
  assign PA_OE_N     = port_a_dir_reg;

endmodule

// ===== common/core_sfr_map.svh
// Address map, field positions, reset values and counts of the special register core
`ifndef CORE_SFR_MAP_SVH
`define CORE_SFR_MAP_SVH

// ----------------------------------------------------------------------------
// Special register addresses (same in both banks)
// ----------------------------------------------------------------------------
`define ADDR_WINDOW0     8'h00
`define ADDR_POINTER0    8'h01
`define ADDR_WINDOW1     8'h02
`define ADDR_POINTER1    8'h03
`define ADDR_BANK_SEL    8'h04
`define ADDR_ACC         8'h05
`define ADDR_PCL         8'h06
`define ADDR_FLAGS       8'h0a
`define ADDR_PORT_A_VAL  8'h12
`define ADDR_PORT_A_DIR  8'h13

// ----------------------------------------------------------------------------
// General purpose RAM window
// ----------------------------------------------------------------------------
`define GP_START         8'h20
`define GP_DEPTH_DEF     64
`define BANKS_DEF        2

// ----------------------------------------------------------------------------
// Flag register fields
// ----------------------------------------------------------------------------
`define FLAG_C_BIT       0
`define FLAG_AC_BIT      1
`define FLAG_Z_BIT       2
`define FLAG_OV_BIT      3
`define FLAG_SLEEP_BIT   4
`define FLAG_WDT_BIT     5

// ----------------------------------------------------------------------------
// Reset values, fixed answers and program counter widths
// ----------------------------------------------------------------------------
`define UNUSED_READ      8'h00
`define ARITH_FLAGS_RST  4'h0
`define PORT_DIR_RST     8'hff
`define PORT_VAL_RST     8'h00
`define ACC_RST          8'h00
`define POINTER_RST      8'h00
`define PC_W_DEF         13
`define PC_LOW_W         8

`endif

// ===== common/core_sfr_pkg.sv
// Types shared by the special register core and its flag unit
package core_sfr_pkg;

  // --------------------------------------------------------------------------
  // Data memory access from the execution unit
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  // --------------------------------------------------------------------------
  // Arithmetic flags, ordered as flag register bits 3..0
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } arith_flags_t;

  // --------------------------------------------------------------------------
  // Operations whose result lands in the accumulator
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_LOAD = 4'h0,
    OP_ADD  = 4'h1,
    OP_ADDC = 4'h2,
    OP_SUB  = 4'h3,
    OP_SUBC = 4'h4,
    OP_AND  = 4'h5,
    OP_OR   = 4'h6,
    OP_XOR  = 4'h7,
    OP_RRC  = 4'h8,
    OP_RLC  = 4'h9
  } alu_op_t;

endpackage

// ===== hw/alu_flag_unit.sv
// Combinational ALU producing the accumulator result and arithmetic flags
`timescale 1ns/1ps

module alu_flag_unit (
  // Operands
  input  logic [7:0]                  a,
  input  logic [7:0]                  b,
  input  logic                        carry_in,
  input  core_sfr_pkg::alu_op_t       op,
  // Results
  output logic [7:0]                  result,
  output core_sfr_pkg::arith_flags_t  flags,
  output core_sfr_pkg::arith_flags_t  update
);

  logic [7:0] b_eff;
  logic       cin_eff;
  logic [4:0] low_sum;
  logic [3:0] high_sum_lo;
  logic [8:0] full_sum;
  logic       carry_into_msb;
  logic       is_arith;
  logic       is_sub;

  // ----------------------------------------------------------------------------
  // Adder shared by add and subtract; OP_SUB is a + ~b + 1, OP_SUBC is a + ~b + carry
  // ----------------------------------------------------------------------------
  assign is_sub   = (op == core_sfr_pkg::OP_SUB) || (op == core_sfr_pkg::OP_SUBC);
  assign is_arith = is_sub || (op == core_sfr_pkg::OP_ADD) || (op == core_sfr_pkg::OP_ADDC);
  assign b_eff    = is_sub ? ~b : b;
  assign cin_eff  = (op == core_sfr_pkg::OP_ADD) ? 1'b0 :
                    (op == core_sfr_pkg::OP_SUB) ? 1'b1 : carry_in;
  assign low_sum  = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};
  assign full_sum = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin_eff};
  // Carry into bit 7 is recovered from the low seven bits and the carry in
  assign high_sum_lo    = {1'b0, a[6:4]} + {1'b0, b_eff[6:4]} + {3'h0, low_sum[4]};
  assign carry_into_msb = high_sum_lo[3];

  // ----------------------------------------------------------------------------
  // Result and flag selection; update marks which flags this op touches
  // ----------------------------------------------------------------------------
  always_comb begin
    result = b;
    flags  = '0;
    update = '0;
    case (op)
      core_sfr_pkg::OP_LOAD: begin
        result = b;
      end
      core_sfr_pkg::OP_ADD, core_sfr_pkg::OP_ADDC,
      core_sfr_pkg::OP_SUB, core_sfr_pkg::OP_SUBC: begin
        result   = full_sum[7:0];
        flags.c  = full_sum[8];
        flags.ac = low_sum[4];
        flags.ov = carry_into_msb ^ full_sum[8];
        update   = 4'hf;
      end
      core_sfr_pkg::OP_AND: begin
        result   = a & b;
        update.z = 1'b1;
      end
      core_sfr_pkg::OP_OR: begin
        result   = a | b;
        update.z = 1'b1;
      end
      core_sfr_pkg::OP_XOR: begin
        result   = a ^ b;
        update.z = 1'b1;
      end
      core_sfr_pkg::OP_RRC: begin
        result   = {carry_in, b[7:1]};
        flags.c  = b[0];
        update.c = 1'b1;
      end
      core_sfr_pkg::OP_RLC: begin
        result   = {b[6:0], carry_in};
        flags.c  = b[7];
        update.c = 1'b1;
      end
      default: begin
        result = b;
      end
    endcase
    // Zero flag follows every arithmetic or logical result
    flags.z = (result == 8'h00);
    if (is_arith) begin
      update.z = 1'b1;
    end
  end

endmodule

// ===== tb/core_sfr_assertions.sv
// Port-level assertions for the special register core
`timescale 1ns/1ps
`include "core_sfr_map.svh"

module core_sfr_checker #(
  parameter int PC_W   = 13,
  parameter int PORT_W = 8
) (
  // Clock and reset
  input wire logic                   SYS_CLK,
  input wire logic                   RST,
  // Memory and ALU
  input wire core_sfr_pkg::mem_req_t MEM_REQ,
  input wire logic [7:0]             MEM_RDATA,
  input wire logic                   ALU_GO,
  input wire core_sfr_pkg::alu_op_t  ALU_OP,
  input wire logic [7:0]             ALU_OPERAND,
  input wire logic [7:0]             ACC_VALUE,
  input wire logic [7:0]             FLAGS_VALUE,
  // Program counter, events, port
  input wire logic [PC_W-1:0]        PC_CURRENT,
  input wire logic                   PC_JUMP,
  input wire logic [PC_W-1:0]        PC_TARGET,
  input wire logic                   DUMMY_CYCLE,
  input wire logic                   WDT_TIMEOUT,
  input wire logic                   WATCHDOG_CLEAR_INSTRUCTION,
  input wire logic                   HALT,
  input wire logic [PORT_W-1:0]      PA_OE_N
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // Decoded strobes keep the properties short
  wire       rd = MEM_REQ.rd;
  wire       wr = MEM_REQ.wr;
  wire [7:0] ad = MEM_REQ.addr;
  a_gap_zero: assert property (rd && ad == 8'h1f |=> MEM_RDATA == 8'h00)
    else $error("gap read not zero");
  a_ptr_top_one: assert property (rd && (ad == 8'h01 || ad == 8'h03) |=> MEM_RDATA[7])
    else $error("pointer bit 7 not one");
  a_flags_top: assert property (FLAGS_VALUE[7:6] == 2'b00)
    else $error("flag bits 7,6 set");
  a_pcl_jump: assert property (wr && ad == `ADDR_PCL |=> PC_JUMP && DUMMY_CYCLE
    && PC_TARGET == {$past(PC_CURRENT[PC_W-1:8]), $past(MEM_REQ.wdata)})
    else $error("page jump wrong");
  a_wdt_set: assert property (WDT_TIMEOUT |=> FLAGS_VALUE[5])
    else $error("watchdog flag not set");
  a_sleep_set: assert property (HALT |=> FLAGS_VALUE[4])
    else $error("sleep flag not set");
  a_clear_both: assert property (WATCHDOG_CLEAR_INSTRUCTION && !WDT_TIMEOUT && !HALT
    |=> FLAGS_VALUE[5:4] == 2'b00)
    else $error("clear left flags");
  a_sys_hold: assert property (!(WDT_TIMEOUT || WATCHDOG_CLEAR_INSTRUCTION || HALT)
    |=> $stable(FLAGS_VALUE[5:4]))
    else $error("system flags moved");
  a_dir_write: assert property (wr && ad == `ADDR_PORT_A_DIR
    |=> PA_OE_N == PORT_W'($past(MEM_REQ.wdata)))
    else $error("direction not taken");
  a_acc_load: assert property (ALU_GO && ALU_OP == core_sfr_pkg::OP_LOAD && !wr
    |=> ACC_VALUE == $past(ALU_OPERAND))
    else $error("load missed accumulator");
  // Main scenarios reached
  c_pcl: cover property (wr && ad == `ADDR_PCL);
  c_halt: cover property (HALT);
  c_win1: cover property (rd && ad == `ADDR_WINDOW1);
endmodule

bind core_special_registers core_sfr_checker #(.PC_W(PC_W), .PORT_W(PORT_W)) chk (
  .SYS_CLK(SYS_CLK), .RST(RST), .MEM_REQ(MEM_REQ), .MEM_RDATA(MEM_RDATA), .ALU_GO(ALU_GO),
  .ALU_OP(ALU_OP), .ALU_OPERAND(ALU_OPERAND), .ACC_VALUE(ACC_VALUE), .FLAGS_VALUE(FLAGS_VALUE),
  .PC_CURRENT(PC_CURRENT), .PC_JUMP(PC_JUMP), .PC_TARGET(PC_TARGET), .DUMMY_CYCLE(DUMMY_CYCLE),
  .WDT_TIMEOUT(WDT_TIMEOUT), .WATCHDOG_CLEAR_INSTRUCTION(WATCHDOG_CLEAR_INSTRUCTION), .HALT(HALT), .PA_OE_N(PA_OE_N));

// ===== tb/exec_unit_model.sv
// Execution unit model issuing memory, ALU and system event requests
`timescale 1ns/1ps

module exec_unit_model (
  // Clock and answer
  input  wire logic             SYS_CLK,
  input  wire logic [7:0]       MEM_RDATA,
  // Requests
  output core_sfr_pkg::mem_req_t MEM_REQ,
  output logic                  ALU_GO,
  output core_sfr_pkg::alu_op_t ALU_OP,
  output logic [7:0]            ALU_OPERAND,
  output logic [12:0]           PC_CURRENT,
  output logic [2:0]            EVENTS
);
  // Idle values; the page sits mid-range so page bits are visible
  initial begin
    MEM_REQ = '0;
    ALU_GO = 1'b0;
    ALU_OP = core_sfr_pkg::OP_LOAD;
    ALU_OPERAND = 8'h00;
    PC_CURRENT = 13'h1234;
    EVENTS = 3'b000;
  end
  // Each request rises on a falling edge and drops on the next one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge SYS_CLK);
    MEM_REQ = '{1'b0, 1'b1, a, d};
    @(negedge SYS_CLK);
    MEM_REQ = '0;
  endtask
  // Read data is settled half a cycle after the taking edge, at the next falling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge SYS_CLK);
    MEM_REQ = '{1'b1, 1'b0, a, 8'h00};
    @(negedge SYS_CLK);
    MEM_REQ = '0;
    d = MEM_RDATA;
  endtask
  task automatic alu(input core_sfr_pkg::alu_op_t op, input logic [7:0] b);
    @(negedge SYS_CLK);
    ALU_GO = 1'b1;
    ALU_OP = op;
    ALU_OPERAND = b;
    @(negedge SYS_CLK);
    ALU_GO = 1'b0;
  endtask
  // Event order is timeout, clear, halt
  task automatic ev(input logic [2:0] e);
    @(negedge SYS_CLK);
    EVENTS = e;
    @(negedge SYS_CLK);
    EVENTS = 3'b000;
  endtask
endmodule

// ===== tb/core_special_registers_bench.sv
// Self-checking bench for the special register core
`timescale 1ns/1ps

module core_special_registers_bench;
  logic                   sys_clk = 1'b0;
  logic                   rst = 1'b1;
  logic [7:0]             pa_in = 8'h3c;
  core_sfr_pkg::mem_req_t req;
  core_sfr_pkg::alu_op_t  op;
  logic [7:0]             rdata, b, acc, flags, pa_out, pa_oe_n;
  logic [12:0]            pc, tgt;
  logic [2:0]             ev;
  logic                   go, jump, dummy, rvalid;
  int                     err_count = 0;
  int                     cmp_count = 0;
  int                     cycles = 0;

  always #5 sys_clk = ~sys_clk;
  core_special_registers uut (.SYS_CLK(sys_clk), .RST(rst), .MEM_REQ(req), .MEM_RDATA(rdata),
    .MEM_RVALID(rvalid), .ALU_GO(go), .ALU_OP(op), .ALU_OPERAND(b), .ACC_VALUE(acc),
    .FLAGS_VALUE(flags), .PC_CURRENT(pc), .PC_JUMP(jump), .PC_TARGET(tgt), .DUMMY_CYCLE(dummy),
    .WDT_TIMEOUT(ev[2]), .WATCHDOG_CLEAR_INSTRUCTION(ev[1]), .HALT(ev[0]), .PA_IN(pa_in), .PA_OUT(pa_out),
    .PA_OE_N(pa_oe_n));
  exec_unit_model eu (.SYS_CLK(sys_clk), .MEM_RDATA(rdata), .MEM_REQ(req), .ALU_GO(go),
    .ALU_OP(op), .ALU_OPERAND(b), .PC_CURRENT(pc), .EVENTS(ev));

  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    eu.rd(a, d);
    chk($sformatf("read %h", a), {8'h00, exp}, {8'h00, d});
    // Read answer flags valid in the cycle after the taking edge
    chk("rvalid", 16'h0001, {15'h0000, rvalid});
  endtask
  // Hang guard: the whole sequence needs well under 400 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      close_out();
    end
  end
  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    rc(8'h0a, 8'h00);
    rc(8'h1f, 8'h00);
    rc(8'h07, 8'h00);
    eu.wr(8'h20, 8'h5a);
    eu.wr(8'h01, 8'h20);
    rc(8'h01, 8'ha0);
    rc(8'h00, 8'h5a);
    eu.wr(8'h00, 8'hc3);
    rc(8'h20, 8'hc3);
    eu.wr(8'h04, 8'h01);
    eu.wr(8'h03, 8'h20);
    eu.wr(8'h02, 8'h77);
    rc(8'h02, 8'h77);
    rc(8'h00, 8'hc3);
    eu.wr(8'h01, 8'h02);
    eu.wr(8'h00, 8'h55);
    rc(8'h00, 8'h00);
    rc(8'h02, 8'h77);
    eu.alu(core_sfr_pkg::OP_LOAD, 8'h7f);
    eu.alu(core_sfr_pkg::OP_ADD, 8'h01);
    chk("acc", 16'h0080, {8'h00, acc});
    chk("flags", 16'h000a, {8'h00, flags});
    eu.alu(core_sfr_pkg::OP_SUB, 8'h80);
    chk("flags", 16'h0007, {8'h00, flags});
    eu.alu(core_sfr_pkg::OP_RRC, 8'h02);
    chk("acc", 16'h0081, {8'h00, acc});
    chk("flags", 16'h0006, {8'h00, flags});
    // Remaining operations; accumulator high byte, flags low byte
    eu.alu(core_sfr_pkg::OP_AND, 8'h0f);
    chk("acc flags", 16'h0102, {acc, flags});
    eu.alu(core_sfr_pkg::OP_RLC, 8'h81);
    chk("acc flags", 16'h0203, {acc, flags});
    eu.alu(core_sfr_pkg::OP_ADDC, 8'hfd);
    chk("acc flags", 16'h0007, {acc, flags});
    eu.alu(core_sfr_pkg::OP_SUBC, 8'h01);
    chk("acc flags", 16'hff00, {acc, flags});
    eu.alu(core_sfr_pkg::OP_OR, 8'h00);
    chk("acc flags", 16'hff00, {acc, flags});
    eu.alu(core_sfr_pkg::OP_XOR, 8'hff);
    chk("acc flags", 16'h0004, {acc, flags});
    eu.wr(8'h0a, 8'hff);
    chk("flags", 16'h000f, {8'h00, flags});
    eu.ev(3'b001);
    chk("flags", 16'h001f, {8'h00, flags});
    eu.ev(3'b100);
    chk("flags", 16'h003f, {8'h00, flags});
    eu.ev(3'b010);
    chk("flags", 16'h000f, {8'h00, flags});
    eu.ev(3'b100);
    eu.ev(3'b001);
    chk("flags", 16'h001f, {8'h00, flags});
    // Time-out and clear together: the time-out is kept
    eu.ev(3'b110);
    chk("flags", 16'h002f, {8'h00, flags});
    eu.wr(8'h06, 8'h56);
    chk("jump", 16'h0003, {14'h0000, dummy, jump});
    chk("target", 16'h1256, {3'b000, tgt});
    eu.wr(8'h13, 8'h0f);
    eu.wr(8'h12, 8'ha5);
    rc(8'h12, 8'hac);
    pa_in = 8'hc3;
    rc(8'h12, 8'ha3);
    chk("oe", 16'h000f, {8'h00, pa_oe_n});
    chk("out", 16'h00a5, {8'h00, pa_out});
    close_out();
  end
endmodule
